// ===== hdl/brc_pkg.sv
`default_nettype none

// Shared constants and carriers for the bus release and bus control registers
package brc_pkg;

	// Register port geometry and offsets
	localparam int unsigned REG_ADDR_W = 4;
	localparam logic [REG_ADDR_W-1:0] REG_REL_OFS = 4'h0;
	localparam logic [REG_ADDR_W-1:0] REG_CTL_OFS = 4'h1;

	// Reset values
	localparam logic [7:0] REL_INIT_NARROW = 8'hfe;
	localparam logic [7:0] REL_INIT_WIDE = 8'hee;
	localparam logic [7:0] CTL_INIT = 8'hc6;
	localparam logic [2:0] RSVD_ONES = 3'h7;

	// Bus release register fields
	localparam int unsigned REL_ADDR23_EN = 7;
	localparam int unsigned REL_ADDR21_EN = 5;
	localparam int unsigned REL_ADDR20_EN = 4;
	localparam int unsigned REL_RSVD_HI = 3;
	localparam int unsigned REL_RSVD_LO = 1;
	localparam int unsigned REL_RELEASE_EN = 0;

	// Bus control register fields
	localparam int unsigned CTL_IDLE_AREA_RD = 7;
	localparam int unsigned CTL_IDLE_RD_WR = 6;
	localparam int unsigned CTL_AREA0_BURST = 5;
	localparam int unsigned CTL_BURST_LEN = 4;
	localparam int unsigned CTL_BURST_WORDS = 3;
	localparam int unsigned CTL_RSVD = 2;
	localparam int unsigned CTL_AREA_DIV = 1;
	localparam int unsigned CTL_WAIT_EN = 0;

	// Operating modes
	localparam int unsigned MODE_W = 3;
	localparam logic [MODE_W-1:0] MODE_3 = 3'h3;
	localparam logic [MODE_W-1:0] MODE_4 = 3'h4;

	// Strap and standby settling after reset or standby
	localparam int unsigned INIT_CNT_W = 3;
	localparam logic [INIT_CNT_W-1:0] INIT_CYCLES_DEF = 3'h2;

	// Burst ROM timing and word grouping
	localparam logic [1:0] BURST_STATES_SHORT = 2'h2;
	localparam logic [1:0] BURST_STATES_LONG = 2'h3;
	localparam int unsigned BURST4_LSB = 3;
	localparam int unsigned BURST8_LSB = 4;

	// Address space and area map
	localparam int unsigned ADDR_W = 24;
	localparam int unsigned AREA_W = 3;
	localparam int unsigned AREA_LSB = 21;
	localparam logic [AREA_W-1:0] AREA_0 = 3'h0;
	localparam logic [ADDR_W-1:0] AREA1_BASE = 24'h200000;
	localparam logic [ADDR_W-1:0] AREA2_BASE = 24'h400000;
	localparam logic [ADDR_W-1:0] AREA3_BASE = 24'hc00000;
	localparam logic [ADDR_W-1:0] AREA4_BASE = 24'he00000;
	localparam logic [ADDR_W-1:0] AREA5_BASE = 24'hff90ea;
	localparam logic [ADDR_W-1:0] AREA6_BASE = 24'hffa0ea;
	localparam logic [ADDR_W-1:0] AREA7_BASE = 24'hffffea;

	// One external bus cycle as announced by the bus controller
	typedef struct packed {
		logic is_read;
		logic [ADDR_W-1:0] addr;
	} brc_cyc_t;

	// Register block phase
	typedef enum logic {
		PH_INIT,
		PH_RUN
	} brc_phase_t;

endpackage : brc_pkg

`default_nettype wire

// ===== hdl/brc_cycle_gap.sv
`default_nettype none

// Decides whether an idle state separates the previous external cycle from the next
module brc_cycle_gap (
	// Previous cycle
	input wire logic prev_valid_i,
	input wire logic prev_read_i,
	input wire logic [brc_pkg::AREA_W-1:0] prev_area_i,
	// Next cycle
	input wire logic cur_read_i,
	input wire logic [brc_pkg::AREA_W-1:0] cur_area_i,
	// Controls
	input wire logic idle_between_area_reads_i,
	input wire logic idle_read_to_write_i,
	// Result
	output logic insert_o
);

	logic area_reads;
	logic read_write;

	// Read followed by read in another area, or read followed by write
	assign area_reads = prev_read_i && cur_read_i && (prev_area_i != cur_area_i);
	assign read_write = prev_read_i && !cur_read_i;
	assign insert_o = prev_valid_i && ((idle_between_area_reads_i && area_reads) ||
		(idle_read_to_write_i && read_write));

endmodule : brc_cycle_gap

`default_nettype wire

// ===== hdl/brc_bus_cfg.sv
// Functional notes
// - Reset or hardware standby loads release register FE in modes 1-2, EE in 3-4.
// - Software standby leaves both registers untouched; only reset and standby initialise.
// - Upper address enable bit 0 makes pin an address output; 1 keeps port.
// - In modes 1 and 2 writes to the upper address enable bits are ignored.
// - Address line 20 enable is unwritable: 0 in modes 3-4, 1 in 1-2.
// - Release register bits 3 to 1 ignore writes and read as one.
// - Release enable 0 never grants the bus; 1 allows bus release.
// - Reset or hardware standby loads the bus control register with C6.
// - Idle enable for reads inserts one idle between reads to different areas.
// - Idle enable for read-write inserts one idle between read then write.
// - Area 0 burst select picks basic or burst ROM interface for area 0.
// - Burst cycle length select gives two states when 0, three when 1.
// - Burst word select allows four words or eight words per burst.
// - Bus control bit 2 is read-only and reads as one.
// - In modes 3-4 area division picks equal or unequal area map.
// - Wait enable honours the wait input; otherwise the input is ignored.
//
// The implementer's own choices: the strobed register port and the register offsets.

`default_nettype none

module brc_bus_cfg #(
	parameter logic [brc_pkg::INIT_CNT_W-1:0] INIT_CYCLES = brc_pkg::INIT_CYCLES_DEF
) (
	// Clock, reset, enable
	input wire logic CLK_I,
	input wire logic ARST_N_I,
	input wire logic CE_I,
	// Register port
	input wire logic [brc_pkg::REG_ADDR_W-1:0] REG_ADDR_I,
	input wire logic [7:0] REG_WDATA_I,
	input wire logic REG_WR_I,
	input wire logic REG_RD_I,
	output logic [7:0] REG_RDATA_O,
	// Pins and straps
	input wire logic [brc_pkg::MODE_W-1:0] MODE_I,
	input wire logic HW_STBY_I,
	input wire logic EXT_BUS_REQUEST_N_I,
	input wire logic WAIT_N_I,
	// External cycle stream from the bus controller
	input wire logic CYC_START_I,
	input wire brc_pkg::brc_cyc_t CYC_I,
	// Pin function and bus controls
	output logic [3:0] ADDR_PIN_IO_O,
	output logic BUS_RELEASE_EN_O,
	output logic BUS_GRANT_O,
	output logic WAIT_EN_O,
	output logic WAIT_STRETCH_O,
	output logic AREA0_BURST_O,
	output logic BURST_WORDS8_O,
	// Per-cycle decisions
	output logic IDLE_INSERT_O,
	output logic BURST_CONT_O,
	output logic [1:0] BURST_STATES_O,
	output logic [brc_pkg::AREA_W-1:0] AREA_O
);

	// Whole state of the block
	typedef struct packed {
		brc_pkg::brc_phase_t phase;
		logic [brc_pkg::INIT_CNT_W-1:0] init_cnt;
		logic [brc_pkg::MODE_W-1:0] mode_s1;
		logic [brc_pkg::MODE_W-1:0] mode_s2;
		logic [brc_pkg::MODE_W-1:0] mode;
		logic hws_s1;
		logic hws_s2;
		logic req_s1;
		logic req_s2;
		logic wait_s1;
		logic wait_s2;
		logic [7:0] rel_reg;
		logic [7:0] ctl_reg;
		logic [7:0] rdata;
		logic grant;
		logic stretch;
		logic prev_valid;
		brc_pkg::brc_cyc_t prev;
		logic [brc_pkg::AREA_W-1:0] prev_area;
		logic idle;
		logic burst_cont;
		logic [1:0] burst_states;
		logic [brc_pkg::AREA_W-1:0] area;
	} brc_state_t;

	brc_state_t st_q;
	brc_state_t st_d;
	logic wide_s2;
	logic run_wide;
	logic [brc_pkg::AREA_W-1:0] cur_area;
	logic gap_insert;
	logic same_group;
	logic burst_ok;

	// Mode decode: strap as sampled, and as latched at the last initialisation
	assign wide_s2 = (st_q.mode_s2 == brc_pkg::MODE_3) || (st_q.mode_s2 == brc_pkg::MODE_4);
	assign run_wide = (st_q.mode == brc_pkg::MODE_3) || (st_q.mode == brc_pkg::MODE_4);

	// Area of the announced cycle; the unequal map only exists in the wide modes
	always_comb
	begin
		cur_area = CYC_I.addr[brc_pkg::ADDR_W-1:brc_pkg::AREA_LSB];
		if (run_wide && !st_q.ctl_reg[brc_pkg::CTL_AREA_DIV])
		begin
			if (CYC_I.addr < brc_pkg::AREA1_BASE)
				cur_area = 3'h0;
			else if (CYC_I.addr < brc_pkg::AREA2_BASE)
				cur_area = 3'h1;
			else if (CYC_I.addr < brc_pkg::AREA3_BASE)
				cur_area = 3'h2;
			else if (CYC_I.addr < brc_pkg::AREA4_BASE)
				cur_area = 3'h3;
			else if (CYC_I.addr < brc_pkg::AREA5_BASE)
				cur_area = 3'h4;
			else if (CYC_I.addr < brc_pkg::AREA6_BASE)
				cur_area = 3'h5;
			else if (CYC_I.addr < brc_pkg::AREA7_BASE)
				cur_area = 3'h6;
			else
				cur_area = 3'h7;
		end
	end

	// Burst continues only inside one 4- or 8-word group of area 0 reads
	assign same_group = st_q.ctl_reg[brc_pkg::CTL_BURST_WORDS] ?
		(CYC_I.addr[brc_pkg::ADDR_W-1:brc_pkg::BURST8_LSB] ==
		st_q.prev.addr[brc_pkg::ADDR_W-1:brc_pkg::BURST8_LSB]) :
		(CYC_I.addr[brc_pkg::ADDR_W-1:brc_pkg::BURST4_LSB] ==
		st_q.prev.addr[brc_pkg::ADDR_W-1:brc_pkg::BURST4_LSB]);
	assign burst_ok = st_q.ctl_reg[brc_pkg::CTL_AREA0_BURST] && st_q.prev_valid &&
		st_q.prev.is_read && CYC_I.is_read && (st_q.prev_area == brc_pkg::AREA_0) &&
		(cur_area == brc_pkg::AREA_0) && same_group;

	// Idle state decision against the previous cycle
	brc_cycle_gap u_gap (
		.prev_valid_i(st_q.prev_valid),
		.prev_read_i(st_q.prev.is_read),
		.prev_area_i(st_q.prev_area),
		.cur_read_i(CYC_I.is_read),
		.cur_area_i(cur_area),
		.idle_between_area_reads_i(st_q.ctl_reg[brc_pkg::CTL_IDLE_AREA_RD]),
		.idle_read_to_write_i(st_q.ctl_reg[brc_pkg::CTL_IDLE_RD_WR]),
		.insert_o(gap_insert)
	);

	// Next state
	always_comb
	begin
		st_d = st_q;
		// Pins cross into the clock domain through two flops
		st_d.mode_s1 = MODE_I;
		st_d.mode_s2 = st_q.mode_s1;
		st_d.hws_s1 = HW_STBY_I;
		st_d.hws_s2 = st_q.hws_s1;
		st_d.req_s1 = EXT_BUS_REQUEST_N_I;
		st_d.req_s2 = st_q.req_s1;
		st_d.wait_s1 = WAIT_N_I;
		st_d.wait_s2 = st_q.wait_s1;
		st_d.rdata = '0;
		unique case (st_q.phase)
			brc_pkg::PH_INIT:
			begin
				// Reload continuously so the settled strap value is what remains
				st_d.mode = st_q.mode_s2;
				st_d.rel_reg = wide_s2 ? brc_pkg::REL_INIT_WIDE : brc_pkg::REL_INIT_NARROW;
				st_d.ctl_reg = brc_pkg::CTL_INIT;
				if (st_q.init_cnt != INIT_CYCLES)
					st_d.init_cnt = st_q.init_cnt + 3'h1;
				else if (!st_q.hws_s2)
					st_d.phase = brc_pkg::PH_RUN;
			end
			brc_pkg::PH_RUN:
			begin
				// Only hardware standby reinitialises; software standby never reaches here
				if (st_q.hws_s2)
				begin
					st_d.phase = brc_pkg::PH_INIT;
					st_d.init_cnt = '0;
				end
				else if (REG_WR_I && (REG_ADDR_I == brc_pkg::REG_REL_OFS))
				begin
					// Bit 4 and bits 3..1 are never taken from the write data
					if (run_wide)
						st_d.rel_reg[brc_pkg::REL_ADDR23_EN:brc_pkg::REL_ADDR21_EN] =
							REG_WDATA_I[brc_pkg::REL_ADDR23_EN:brc_pkg::REL_ADDR21_EN];
					st_d.rel_reg[brc_pkg::REL_RELEASE_EN] =
						REG_WDATA_I[brc_pkg::REL_RELEASE_EN];
				end
				else if (REG_WR_I && (REG_ADDR_I == brc_pkg::REG_CTL_OFS))
				begin
					st_d.ctl_reg = REG_WDATA_I;
					st_d.ctl_reg[brc_pkg::CTL_RSVD] = 1'b1;
				end
			end
		endcase
		// Read data stands for exactly one cycle after the strobe
		if (REG_RD_I)
		begin
			if (REG_ADDR_I == brc_pkg::REG_REL_OFS)
				st_d.rdata = st_q.rel_reg;
			else if (REG_ADDR_I == brc_pkg::REG_CTL_OFS)
				st_d.rdata = st_q.ctl_reg;
		end
		// Grant follows the request only while release is enabled
		st_d.grant = !st_q.req_s2 && st_q.rel_reg[brc_pkg::REL_RELEASE_EN];
		st_d.stretch = !st_q.wait_s2 && st_q.ctl_reg[brc_pkg::CTL_WAIT_EN];
		// Per-cycle decisions held until the next announced cycle
		if (CYC_START_I)
		begin
			st_d.area = cur_area;
			st_d.idle = gap_insert;
			st_d.burst_cont = burst_ok;
			st_d.burst_states = st_q.ctl_reg[brc_pkg::CTL_BURST_LEN] ?
				brc_pkg::BURST_STATES_LONG : brc_pkg::BURST_STATES_SHORT;
			st_d.prev = CYC_I;
			st_d.prev_area = cur_area;
			st_d.prev_valid = 1'b1;
		end
	end

	// State register; the strap is caught later by the init phase, never at reset
	always_ff @(posedge CLK_I or negedge ARST_N_I)
	begin
		if (!ARST_N_I)
		begin
			st_q <= '0;
			st_q.req_s1 <= 1'b1;
			st_q.req_s2 <= 1'b1;
			st_q.wait_s1 <= 1'b1;
			st_q.wait_s2 <= 1'b1;
			st_q.rel_reg <= brc_pkg::REL_INIT_NARROW;
			st_q.ctl_reg <= brc_pkg::CTL_INIT;
		end
		else if (CE_I)
			st_q <= st_d;
	end

	// Outputs straight from the state
	assign REG_RDATA_O = st_q.rdata;
	assign ADDR_PIN_IO_O = st_q.rel_reg[brc_pkg::REL_ADDR23_EN:brc_pkg::REL_ADDR20_EN];
	assign BUS_RELEASE_EN_O = st_q.rel_reg[brc_pkg::REL_RELEASE_EN];
	assign BUS_GRANT_O = st_q.grant;
	assign WAIT_EN_O = st_q.ctl_reg[brc_pkg::CTL_WAIT_EN];
	assign WAIT_STRETCH_O = st_q.stretch;
	assign AREA0_BURST_O = st_q.ctl_reg[brc_pkg::CTL_AREA0_BURST];
	assign BURST_WORDS8_O = st_q.ctl_reg[brc_pkg::CTL_BURST_WORDS];
	assign IDLE_INSERT_O = st_q.idle;
	assign BURST_CONT_O = st_q.burst_cont;
	assign BURST_STATES_O = st_q.burst_states;
	assign AREA_O = st_q.area;

	// Checks
	default clocking cb @(posedge CLK_I);
	endclocking
	default disable iff (!ARST_N_I);

	sequence read_start_s;
		CE_I && CYC_START_I && CYC_I.is_read;
	endsequence

	sequence write_start_s;
		CE_I && CYC_START_I && !CYC_I.is_read;
	endsequence

	// The cycle before the announced one was an external read
	sequence after_read_s;
		st_q.prev_valid && st_q.prev.is_read;
	endsequence

	init_release_a: assert property (
		(st_q.phase == brc_pkg::PH_INIT) && CE_I ##1 (st_q.phase == brc_pkg::PH_RUN) |->
		(st_q.rel_reg == (run_wide ? brc_pkg::REL_INIT_WIDE : brc_pkg::REL_INIT_NARROW)))
		else $error("release register not at mode value after init");

	init_control_a: assert property (
		(st_q.phase == brc_pkg::PH_INIT) && CE_I |=> (st_q.ctl_reg == brc_pkg::CTL_INIT))
		else $error("bus control register not at its initial value");

	regs_hold_a: assert property (
		CE_I && (st_q.phase == brc_pkg::PH_RUN) && !st_q.hws_s2 && !REG_WR_I |=>
		$stable(st_q.rel_reg) && $stable(st_q.ctl_reg))
		else $error("register changed without write or standby");

	addr_write_a: assert property (
		CE_I && (st_q.phase == brc_pkg::PH_RUN) && !st_q.hws_s2 && run_wide && REG_WR_I &&
		(REG_ADDR_I == brc_pkg::REG_REL_OFS) |=>
		ADDR_PIN_IO_O[3:1] ==
		$past(REG_WDATA_I[brc_pkg::REL_ADDR23_EN:brc_pkg::REL_ADDR21_EN]))
		else $error("upper address enables did not take the write");

	addr_lock_a: assert property (
		CE_I && (st_q.phase == brc_pkg::PH_RUN) && !run_wide && !st_q.hws_s2 |=>
		$stable(ADDR_PIN_IO_O[3:1]))
		else $error("upper address enables changed in modes 1 or 2");

	a20_fixed_a: assert property (
		(st_q.phase == brc_pkg::PH_RUN) |-> (ADDR_PIN_IO_O[0] == !run_wide))
		else $error("address line 20 enable not at its mode value");

	rsvd_ones_a: assert property (
		st_q.rel_reg[brc_pkg::REL_RSVD_HI:brc_pkg::REL_RSVD_LO] == brc_pkg::RSVD_ONES)
		else $error("release register reserved bits not one");

	no_grant_a: assert property (
		CE_I && !BUS_RELEASE_EN_O |=> !BUS_GRANT_O)
		else $error("bus granted while release disabled");

	grant_follow_a: assert property (
		CE_I && BUS_RELEASE_EN_O && !st_q.req_s2 |=> BUS_GRANT_O)
		else $error("enabled request not granted");

	// Starts may be spaced apart, so the prior cycle is taken from the held state
	idle_areas_a: assert property (
		read_start_s ##0 after_read_s ##0
		(st_q.ctl_reg[brc_pkg::CTL_IDLE_AREA_RD] && (cur_area != st_q.prev_area)) |=>
		IDLE_INSERT_O)
		else $error("no idle between reads to different areas");

	idle_rdwr_a: assert property (
		write_start_s ##0 after_read_s ##0 st_q.ctl_reg[brc_pkg::CTL_IDLE_RD_WR] |=>
		IDLE_INSERT_O)
		else $error("no idle between read and write");

	idle_off_a: assert property (
		CE_I && CYC_START_I && !st_q.ctl_reg[brc_pkg::CTL_IDLE_RD_WR] &&
		!st_q.ctl_reg[brc_pkg::CTL_IDLE_AREA_RD] |=> !IDLE_INSERT_O)
		else $error("idle inserted while both idle enables are off");

	burst_area0_a: assert property (
		CE_I && CYC_START_I && !st_q.ctl_reg[brc_pkg::CTL_AREA0_BURST] |=> !BURST_CONT_O)
		else $error("burst continued on a basic area 0");

	burst_len_a: assert property (
		CE_I && CYC_START_I |=>
		BURST_STATES_O == ($past(st_q.ctl_reg[brc_pkg::CTL_BURST_LEN]) ?
		brc_pkg::BURST_STATES_LONG : brc_pkg::BURST_STATES_SHORT))
		else $error("burst cycle length wrong");

	burst_group_a: assert property (
		CE_I && CYC_START_I && !st_q.ctl_reg[brc_pkg::CTL_BURST_WORDS] &&
		(CYC_I.addr[brc_pkg::BURST4_LSB] != st_q.prev.addr[brc_pkg::BURST4_LSB]) |=>
		!BURST_CONT_O)
		else $error("burst crossed a four word group");

	bcr_rsvd_a: assert property (
		st_q.ctl_reg[brc_pkg::CTL_RSVD])
		else $error("bus control bit 2 not one");

	area_equal_a: assert property (
		CE_I && CYC_START_I && (!run_wide || st_q.ctl_reg[brc_pkg::CTL_AREA_DIV]) |=>
		AREA_O == $past(CYC_I.addr[brc_pkg::ADDR_W-1:brc_pkg::AREA_LSB]))
		else $error("equal area decode wrong");

	wait_gate_a: assert property (
		CE_I && !WAIT_EN_O |=> !WAIT_STRETCH_O)
		else $error("wait honoured while disabled");

endmodule : brc_bus_cfg

`default_nettype wire

// ===== sim/brc_ext_partner.sv
`default_nettype none

// Far side stand-in: an external bus master and a slow memory pulling the wait line
module brc_ext_partner (
	// Clock and reset
	input wire logic clk_i,
	input wire logic arst_n_i,
	// Commands from the bench
	input wire logic want_bus_i,
	input wire logic rude_i,
	input wire logic want_wait_i,
	// Device state the master looks at
	input wire logic release_en_i,
	// Pins, pulled up when idle
	output logic bus_request_n_o,
	output logic wait_n_o
);
	timeunit 1ns;
	timeprecision 1ps;

	// A polite master asks only once release is on; rude_i breaks that for the refusal case
	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			bus_request_n_o <= 1'b1;
			wait_n_o <= 1'b1;
		end
		else
		begin
			bus_request_n_o <= !(want_bus_i && (release_en_i || rude_i));
			wait_n_o <= !want_wait_i;
		end
	end
endmodule : brc_ext_partner

`default_nettype wire

// ===== sim/tb_top.sv
`default_nettype none

module tb_top;
	timeunit 1ns;
	timeprecision 1ps;

	// Bench drive and observation signals
	logic clk, arst_n, ce, wr, rd, hw_stby, cyc_start, want_bus, rude, want_wait;
	logic req_n, wait_n, rel_en, grant, wait_en, stretch, burst_en, words8, idle, cont;
	logic [3:0] addr, pin_io;
	logic [7:0] wdata, rdata, w, exp_rel, ctl;
	logic [2:0] mode, area, p_area;
	logic [1:0] states;
	logic [23:0] p_addr;
	logic p_val, p_rd;
	logic [7:0] ctl_tab [5] = '{8'h80, 8'h42, 8'h38, 8'h20, 8'hfb};
	brc_pkg::brc_cyc_t cyc;
	int n_errors, checks, seed;

	brc_bus_cfg #(.INIT_CYCLES(brc_pkg::INIT_CYCLES_DEF)) i_dut (
		.CLK_I(clk), .ARST_N_I(arst_n), .CE_I(ce),
		.REG_ADDR_I(addr), .REG_WDATA_I(wdata), .REG_WR_I(wr), .REG_RD_I(rd),
		.REG_RDATA_O(rdata), .MODE_I(mode), .HW_STBY_I(hw_stby),
		.EXT_BUS_REQUEST_N_I(req_n), .WAIT_N_I(wait_n),
		.CYC_START_I(cyc_start), .CYC_I(cyc),
		.ADDR_PIN_IO_O(pin_io), .BUS_RELEASE_EN_O(rel_en), .BUS_GRANT_O(grant),
		.WAIT_EN_O(wait_en), .WAIT_STRETCH_O(stretch), .AREA0_BURST_O(burst_en),
		.BURST_WORDS8_O(words8), .IDLE_INSERT_O(idle), .BURST_CONT_O(cont),
		.BURST_STATES_O(states), .AREA_O(area)
	);

	brc_ext_partner i_ext (
		.clk_i(clk), .arst_n_i(arst_n), .want_bus_i(want_bus), .rude_i(rude),
		.want_wait_i(want_wait), .release_en_i(rel_en),
		.bus_request_n_o(req_n), .wait_n_o(wait_n)
	);

	// 40 MHz clock
	initial
	begin
		clk = 1'b0;
		forever #12.5 clk = !clk;
	end

	// Compare and count
	task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
		checks++;
		if (got !== exp)
		begin
			n_errors++;
			$display("Error %s expected %h seen %h", name, exp, got);
		end
	endtask : chk

	task automatic summarize();
		if (n_errors == 0 && checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : summarize

	// Area a cycle falls in; the unequal map is walked from the lowest base up
	function automatic logic [2:0] area_of(input logic uneq, input logic [23:0] a);
		logic [23:0] base [8] = '{24'h0, brc_pkg::AREA1_BASE, brc_pkg::AREA2_BASE,
			brc_pkg::AREA3_BASE, brc_pkg::AREA4_BASE, brc_pkg::AREA5_BASE,
			brc_pkg::AREA6_BASE, brc_pkg::AREA7_BASE};
		area_of = a[23:21];
		if (uneq)
			for (int i = 0; i < 8; i++)
				if (a >= base[i])
					area_of = i[2:0];
	endfunction : area_of

	// Strobes last one cycle; a full edge passes before the next request
	task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
	endtask : reg_wr

	// Read data stand only in the cycle after the strobe, so look there
	task automatic reg_rd(input logic [3:0] a, input logic [7:0] exp, input string name);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		@(negedge clk);
		chk(name, exp, rdata);
	endtask : reg_rd

	task automatic reset_dut(input logic [2:0] m);
		@(posedge clk);
		arst_n <= 1'b0;
		mode <= m;
		p_val = 1'b0;
		repeat (16) @(posedge clk);
		arst_n <= 1'b1;
		repeat (8) @(posedge clk);
	endtask : reset_dut

	// One external cycle, judged against the previous one and the control value
	task automatic bus_cyc(input logic r, input logic [23:0] a, input logic m34);
		logic [2:0] ar;
		logic e_idle, e_cont;
		ar = area_of(m34 && !ctl[brc_pkg::CTL_AREA_DIV], a);
		e_idle = p_val && p_rd && ((r && ar != p_area && ctl[7]) || (!r && ctl[6]));
		e_cont = p_val && p_rd && r && ctl[5] && ar == 3'h0 && p_area == 3'h0
			&& (ctl[3] ? p_addr[23:4] == a[23:4] : p_addr[23:3] == a[23:3]);
		@(posedge clk);
		cyc_start <= 1'b1;
		cyc <= '{is_read: r, addr: a};
		@(posedge clk);
		cyc_start <= 1'b0;
		@(negedge clk);
		chk("area", {5'h0, ar}, {5'h0, area});
		chk("idle", {7'h0, e_idle}, {7'h0, idle});
		chk("burst continue", {7'h0, e_cont}, {7'h0, cont});
		chk("burst states", ctl[4] ? 8'h03 : 8'h02, {6'h0, states});
		p_val = 1'b1;
		p_rd = r;
		p_area = ar;
		p_addr = a;
	endtask : bus_cyc

	// Watchdog, far beyond the fewer than a thousand cycles the run needs
	initial
	begin
		repeat (20000) @(posedge clk);
		n_errors++;
		summarize();
	end

	// Main sequence: once in a narrow mode, once in each wide mode
	initial
	begin
		seed = 32'haedf;
		n_errors = 0;
		checks = 0;
		{arst_n, ce, wr, rd, hw_stby, cyc_start, want_bus, rude, want_wait} = 9'h080;
		addr = 4'h0;
		wdata = 8'h00;
		mode = 3'h1;
		cyc = '0;
		// Modes 1, 3 and 4: one narrow and both wide straps
		for (int m = 1; m <= 4; m += (m == 1) ? 2 : 1)
		begin
			reset_dut(m[2:0]);
			exp_rel = (m > 2) ? brc_pkg::REL_INIT_WIDE : brc_pkg::REL_INIT_NARROW;
			reg_rd(brc_pkg::REG_REL_OFS, exp_rel, "release init");
			reg_rd(brc_pkg::REG_CTL_OFS, 8'hc6, "control init");
			reg_rd(4'h9, 8'h00, "unmapped");
			repeat (8)
			begin
				w = 8'($random(seed));
				exp_rel = (m > 2) ? {w[7:5], 4'h7, w[0]} : {7'h7f, w[0]};
				reg_wr(brc_pkg::REG_REL_OFS, w);
				reg_rd(brc_pkg::REG_REL_OFS, exp_rel, "release");
				chk("pin function", {4'h0, exp_rel[7:4]}, {4'h0, pin_io});
				chk("release enable", {7'h0, w[0]}, {7'h0, rel_en});
				w = 8'($random(seed));
				reg_wr(brc_pkg::REG_CTL_OFS, w);
				reg_rd(brc_pkg::REG_CTL_OFS, w | 8'h04, "control");
				chk("control fields", {5'h0, w[5], w[3], w[0]},
					{5'h0, burst_en, words8, wait_en});
			end
			// A stopped clock must not lose the settings
			@(posedge clk);
			ce <= 1'b0;
			repeat (20) @(posedge clk);
			ce <= 1'b1;
			reg_rd(brc_pkg::REG_REL_OFS, exp_rel, "after clock stop");
			// Request while release is off is refused, then granted once enabled
			reg_wr(brc_pkg::REG_REL_OFS, 8'hfe);
			want_bus <= 1'b1;
			rude <= 1'b1;
			repeat (6) @(negedge clk);
			chk("grant refused", 8'h00, {7'h0, grant});
			rude <= 1'b0;
			reg_wr(brc_pkg::REG_REL_OFS, 8'hff);
			repeat (6) @(negedge clk);
			chk("grant", 8'h01, {7'h0, grant});
			want_bus <= 1'b0;
			repeat (6) @(negedge clk);
			chk("grant dropped", 8'h00, {7'h0, grant});
			// Wait input honoured only while enabled
			want_wait <= 1'b1;
			reg_wr(brc_pkg::REG_CTL_OFS, 8'h01);
			repeat (6) @(negedge clk);
			chk("stretch on", 8'h01, {7'h0, stretch});
			reg_wr(brc_pkg::REG_CTL_OFS, 8'h00);
			repeat (6) @(negedge clk);
			chk("stretch off", 8'h00, {7'h0, stretch});
			want_wait <= 1'b0;
			// Fixed cycle patterns under each control setting, then random ones
			foreach (ctl_tab[i])
			begin
				ctl = ctl_tab[i];
				reg_wr(brc_pkg::REG_CTL_OFS, ctl);
				bus_cyc(1'b1, 24'h000000, m > 2);
				bus_cyc(1'b1, 24'h000004, m > 2);
				bus_cyc(1'b1, 24'h000008, m > 2);
				bus_cyc(1'b1, 24'h600000, m > 2);
				bus_cyc(1'b0, 24'h600010, m > 2);
				repeat (4) bus_cyc(1'($random(seed)), 24'($random(seed)), m > 2);
			end
		end
		// Hardware standby brings back the initial values
		reg_wr(brc_pkg::REG_CTL_OFS, 8'h00);
		@(posedge clk);
		hw_stby <= 1'b1;
		repeat (4) @(posedge clk);
		hw_stby <= 1'b0;
		repeat (10) @(posedge clk);
		reg_rd(brc_pkg::REG_REL_OFS, brc_pkg::REL_INIT_WIDE, "standby release");
		reg_rd(brc_pkg::REG_CTL_OFS, brc_pkg::CTL_INIT, "standby control");
		summarize();
	end
endmodule : tb_top

`default_nettype wire
